// File: core/cmx_mailbox_ctrl.sv
// Mailbox transmit and receive control for one CAN channel
//
// Contract
// - Sixteen mailboxes, each transmit or receive.
// - Normal transmit success sets success flag.
// - Normal transmit retries after loss or error.
// - Single-attempt transmit never retries.
// - Single-attempt success sets success flag.
// - Single-attempt loss or error sets abort-done.
// - No completion event on loss or error.
// - Abort before start sets abort-done.
// - Abort then loss or error: drop, abort-done.
// - Success despite abort: success flag only.
// - Lower priority identifier loses, stops sending.
// - Complete only after winning or idle bus.
// - Store in lowest-numbered matching receive mailbox.
// - Accept frames matching identifier under mask.
// - Single-attempt receive stores only one message.
// - Full single-attempt boxes pass to next higher.
// - Overwrite mode replaces unprocessed message.
// - Overwrite while new flag set sets lost.
// - Overrun mode discards, sets lost, raises event.
// - Mode from request bits; 11x prohibited.
// - Full single-attempt box accepts nothing more.
// - Reception abort by clearing request and flags.
// - Own frames received only in self-test, acknowledged.
`timescale 1ns/1ps

module cmx_mailbox_ctrl (
  input wire logic clk, // 40 MHz peripheral clock
  input wire logic rst, // Synchronous, active high
  input wire logic ce, // Clock enable, freezes all state
  input wire logic [cmx_pkg::ADDR_W-1:0] reg_addr, // Register index
  input wire logic [cmx_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [cmx_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
  output logic tx_valid, // Frame offered to protocol engine
  output logic [cmx_pkg::IDX_W-1:0] tx_index, // Offered mailbox
  input wire logic tx_start, // Engine began the frame
  input wire logic tx_ok, // Frame sent, arbitration won
  input wire logic tx_arb_lost, // Arbitration lost
  input wire logic tx_bus_err, // Bus error during frame
  output logic tx_done_pulse, // Successful completion event
  input wire logic rx_valid, // Received frame, one cycle
  input wire logic [cmx_pkg::ID_W-1:0] rx_id, // Received identifier
  input wire logic rx_own, // Frame was our own transmission
  output logic rx_store, // Write frame into mailbox store
  output logic [cmx_pkg::IDX_W-1:0] rx_store_idx, // Target mailbox
  output logic overrun_pulse, // Overrun event
  output logic ack_own // Acknowledge own frames
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Transmit mode: request 1, receive 0; 11x is prohibited
  function automatic logic is_tx(input logic [cmx_pkg::CTRL_W-1:0] c);
    is_tx = c[cmx_pkg::B_TX_REQ] & ~c[cmx_pkg::B_RX_REQ];
  endfunction

  // Receive mode: receive 1, transmit 0
  function automatic logic is_rx(input logic [cmx_pkg::CTRL_W-1:0] c);
    is_rx = c[cmx_pkg::B_RX_REQ] & ~c[cmx_pkg::B_TX_REQ];
  endfunction

  // Lowest set bit, found flag on top
  function automatic logic [cmx_pkg::IDX_W:0] first_set(
    input logic [cmx_pkg::MBOX_NUM-1:0] v
  );
    logic [cmx_pkg::IDX_W:0] r;
    r = '0;
    for (int j = cmx_pkg::MBOX_NUM - 1; j >= 0; j--) begin
      if (v[j]) begin
        r = {1'b1, cmx_pkg::IDX_W'(j)};
      end
    end
    first_set = r;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [cmx_pkg::CTRL_W-1:0] ctrl_q [cmx_pkg::MBOX_NUM];
  logic [cmx_pkg::CTRL_W-1:0] ctrl_d [cmx_pkg::MBOX_NUM];
  logic [cmx_pkg::ID_W-1:0] id_q [cmx_pkg::MBOX_NUM]; // Mailbox ids
  logic [cmx_pkg::ID_W-1:0] id_d [cmx_pkg::MBOX_NUM];
  logic [cmx_pkg::MBOX_NUM-1:0] abt_q, abt_d; // Abort pending
  logic [cmx_pkg::ID_W-1:0] mask_q, mask_d; // 1 = bit compared
  logic [cmx_pkg::CFG_W-1:0] cfg_q, cfg_d; // Mode bits
  cmx_pkg::cmx_tx_state_t st_q, st_d; // Scheduler state
  logic [cmx_pkg::IDX_W-1:0] cur_q, cur_d; // Mailbox in flight
  logic done_q, done_d; // Completion event
  logic store_q, store_d; // Store event
  logic [cmx_pkg::IDX_W-1:0] sidx_q, sidx_d; // Store target
  logic ovr_q, ovr_d; // Overrun event
  logic [cmx_pkg::DATA_W-1:0] rdata_q, rdata_d; // Read data

  // Decoded request, shared by the update and read paths
  logic [1:0] sel;
  logic [cmx_pkg::IDX_W-1:0] widx;
  assign sel = reg_addr[cmx_pkg::ADDR_W-1:cmx_pkg::IDX_W];
  assign widx = reg_addr[cmx_pkg::IDX_W-1:0];

  // Candidate vectors for the priority pickers
  logic [cmx_pkg::MBOX_NUM-1:0] tx_cand, rx_cand;
  logic [cmx_pkg::IDX_W:0] tx_pick, rx_pick;
  logic rx_take;

  // ************************************************************
  // Candidate search
  // ************************************************************

  // Pending transmit boxes, and receive boxes able to take the frame
  always_comb begin
    for (int j = 0; j < cmx_pkg::MBOX_NUM; j++) begin
      tx_cand[j] = is_tx(ctrl_q[j]) & ~abt_q[j];
      // Full single-attempt boxes drop out so the next one catches
      rx_cand[j] = is_rx(ctrl_q[j])
        & (((rx_id ^ id_q[j]) & mask_q) == '0)
        & ~(ctrl_q[j][cmx_pkg::B_SINGLE]
          & ctrl_q[j][cmx_pkg::B_RX_NEW]);
    end
  end
  assign tx_pick = first_set(tx_cand);
  assign rx_pick = first_set(rx_cand);
  // Own frames pass only in self-test
  assign rx_take = rx_valid
    & (~rx_own | cfg_q[cmx_pkg::C_SELF_TEST]);

  // ************************************************************
  // Next state: software writes first, hardware events after
  // ************************************************************

  // Hardware sets come last so they win over a same-cycle clear
  always_comb begin
    logic [cmx_pkg::CTRL_W-1:0] old;
    logic [cmx_pkg::CTRL_W-1:0] nv;
    logic [cmx_pkg::IDX_W-1:0] r;
    old = '0;
    nv = '0;
    r = rx_pick[cmx_pkg::IDX_W-1:0];
    ctrl_d = ctrl_q;
    id_d = id_q;
    abt_d = abt_q;
    mask_d = mask_q;
    cfg_d = cfg_q;
    st_d = st_q;
    cur_d = cur_q;
    done_d = 1'b0;
    store_d = 1'b0;
    sidx_d = sidx_q;
    ovr_d = 1'b0;
    // Register writes
    if (reg_wr) begin
      if (sel == cmx_pkg::SEL_CTRL) begin
        old = ctrl_q[widx];
        nv = reg_wdata[cmx_pkg::CTRL_W-1:0];
        ctrl_d[widx][cmx_pkg::B_TX_REQ] = nv[cmx_pkg::B_TX_REQ];
        ctrl_d[widx][cmx_pkg::B_RX_REQ] = nv[cmx_pkg::B_RX_REQ];
        ctrl_d[widx][cmx_pkg::B_SINGLE] = nv[cmx_pkg::B_SINGLE];
        // Flags clear on a written 0, writing 1 keeps them
        ctrl_d[widx][cmx_pkg::B_RX_NEW] =
          old[cmx_pkg::B_RX_NEW] & nv[cmx_pkg::B_RX_NEW];
        ctrl_d[widx][cmx_pkg::B_RX_LOST] =
          old[cmx_pkg::B_RX_LOST] & nv[cmx_pkg::B_RX_LOST];
        ctrl_d[widx][cmx_pkg::B_TX_OK] =
          old[cmx_pkg::B_TX_OK] & nv[cmx_pkg::B_TX_OK];
        ctrl_d[widx][cmx_pkg::B_TX_ABT] =
          old[cmx_pkg::B_TX_ABT] & nv[cmx_pkg::B_TX_ABT];
        // Dropping the transmit request starts an abort
        if (is_tx(old) && !nv[cmx_pkg::B_TX_REQ]) begin
          abt_d[widx] = 1'b1;
        end
      end else if (sel == cmx_pkg::SEL_ID) begin
        id_d[widx] = reg_wdata[cmx_pkg::ID_W-1:0];
      end else if (reg_addr == cmx_pkg::MASK_ADDR) begin
        mask_d = reg_wdata[cmx_pkg::ID_W-1:0];
      end else if (reg_addr == cmx_pkg::CFG_ADDR) begin
        cfg_d = reg_wdata[cmx_pkg::CFG_W-1:0];
      end
    end
    // Aborts of boxes not in flight complete at once
    for (int j = 0; j < cmx_pkg::MBOX_NUM; j++) begin
      if (abt_q[j] && !(st_q != cmx_pkg::TX_IDLE
          && cur_q == cmx_pkg::IDX_W'(j))) begin
        ctrl_d[j][cmx_pkg::B_TX_ABT] = 1'b1;
        ctrl_d[j][cmx_pkg::B_TX_REQ] = 1'b0;
        abt_d[j] = 1'b0;
      end
    end
    // Transmit scheduler
    unique case (st_q)
      cmx_pkg::TX_IDLE: begin
        // Lowest pending box is offered first
        if (tx_pick[cmx_pkg::IDX_W]) begin
          cur_d = tx_pick[cmx_pkg::IDX_W-1:0];
          st_d = cmx_pkg::TX_OFFER;
        end
      end
      cmx_pkg::TX_OFFER: begin
        // A start in the abort cycle still counts as started
        if (tx_start) begin
          st_d = cmx_pkg::TX_ACTIVE;
        end else if (abt_q[cur_q]) begin
          ctrl_d[cur_q][cmx_pkg::B_TX_ABT] = 1'b1;
          ctrl_d[cur_q][cmx_pkg::B_TX_REQ] = 1'b0;
          abt_d[cur_q] = 1'b0;
          st_d = cmx_pkg::TX_IDLE;
        end
      end
      cmx_pkg::TX_ACTIVE: begin
        if (tx_ok) begin
          // Only a won or idle-bus frame counts as complete
          ctrl_d[cur_q][cmx_pkg::B_TX_OK] = 1'b1;
          ctrl_d[cur_q][cmx_pkg::B_TX_REQ] = 1'b0;
          abt_d[cur_q] = 1'b0;
          done_d = 1'b1;
          st_d = cmx_pkg::TX_IDLE;
        end else if (tx_arb_lost || tx_bus_err) begin
          // Engine has stopped sending; no completion event here
          if (ctrl_q[cur_q][cmx_pkg::B_SINGLE] || abt_q[cur_q]) begin
            ctrl_d[cur_q][cmx_pkg::B_TX_ABT] = 1'b1;
            ctrl_d[cur_q][cmx_pkg::B_TX_REQ] = 1'b0;
            abt_d[cur_q] = 1'b0;
          end
          // Normal box keeps its request and is offered again
          st_d = cmx_pkg::TX_IDLE;
        end
      end
      default: begin
        st_d = cmx_pkg::TX_IDLE;
      end
    endcase
    // Receive placement
    if (rx_take && rx_pick[cmx_pkg::IDX_W]) begin
      if (ctrl_q[r][cmx_pkg::B_RX_NEW]) begin
        ctrl_d[r][cmx_pkg::B_RX_LOST] = 1'b1;
        if (cfg_q[cmx_pkg::C_LOST_MODE]) begin
          ovr_d = cfg_q[cmx_pkg::C_OVR_IE];
        end else begin
          store_d = 1'b1;
          // New data stands even if software clears it in this cycle
          ctrl_d[r][cmx_pkg::B_RX_NEW] = 1'b1;
          sidx_d = r;
        end
      end else begin
        ctrl_d[r][cmx_pkg::B_RX_NEW] = 1'b1;
        store_d = 1'b1;
        sidx_d = r;
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************

  // Data stand one cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = cmx_pkg::RD_ZERO;
    if (reg_rd) begin
      if (sel == cmx_pkg::SEL_CTRL) begin
        rdata_d[cmx_pkg::CTRL_W-1:0] = ctrl_q[widx];
        // Lets software wait out an abort before a new request
        rdata_d[cmx_pkg::B_ABT_BUSY] = abt_q[widx];
      end else if (sel == cmx_pkg::SEL_ID) begin
        rdata_d[cmx_pkg::ID_W-1:0] = id_q[widx];
      end else if (reg_addr == cmx_pkg::MASK_ADDR) begin
        rdata_d[cmx_pkg::ID_W-1:0] = mask_q;
      end else if (reg_addr == cmx_pkg::CFG_ADDR) begin
        rdata_d[cmx_pkg::CFG_W-1:0] = cfg_q;
      end else if (reg_addr == cmx_pkg::STAT_ADDR) begin
        rdata_d[cmx_pkg::IDX_W+1:0] = {st_q, cur_q};
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Single register stage for all state, frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int j = 0; j < cmx_pkg::MBOX_NUM; j++) begin
        ctrl_q[j] <= cmx_pkg::CTRL_RST;
        id_q[j] <= cmx_pkg::ID_RST;
      end
      abt_q <= '0;
      mask_q <= cmx_pkg::MASK_RST;
      cfg_q <= cmx_pkg::CFG_RST;
      st_q <= cmx_pkg::TX_IDLE;
      cur_q <= '0;
      done_q <= 1'b0;
      store_q <= 1'b0;
      sidx_q <= '0;
      ovr_q <= 1'b0;
      rdata_q <= cmx_pkg::RD_ZERO;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      id_q <= id_d;
      abt_q <= abt_d;
      mask_q <= mask_d;
      cfg_q <= cfg_d;
      st_q <= st_d;
      cur_q <= cur_d;
      done_q <= done_d;
      store_q <= store_d;
      sidx_q <= sidx_d;
      ovr_q <= ovr_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign tx_valid = (st_q == cmx_pkg::TX_OFFER);
  assign tx_index = cur_q;
  assign tx_done_pulse = done_q;
  assign rx_store = store_q;
  assign rx_store_idx = sidx_q;
  assign overrun_pulse = ovr_q;
  assign ack_own = cfg_q[cmx_pkg::C_SELF_TEST];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic fail_ev; // Loss or error in flight
  assign fail_ev = (st_q == cmx_pkg::TX_ACTIVE) && !tx_ok
    && (tx_arb_lost || tx_bus_err);

  sequence s_started;
    ce && st_q == cmx_pkg::TX_OFFER && tx_start;
  endsequence
  sequence s_won;
    ce && st_q == cmx_pkg::TX_ACTIVE && tx_ok;
  endsequence

  a_start_active: assert property (s_started |=>
    st_q == cmx_pkg::TX_ACTIVE)
    else $error("started frame not active");
  a_ok_sets_flag: assert property (s_won |=>
    ctrl_q[$past(cur_q)][cmx_pkg::B_TX_OK] && done_q
    && !ctrl_q[$past(cur_q)][cmx_pkg::B_TX_REQ])
    else $error("success flag missing");
  a_ok_no_abort: assert property ((s_won
    and !ctrl_q[cur_q][cmx_pkg::B_TX_ABT]) |=>
    !ctrl_q[$past(cur_q)][cmx_pkg::B_TX_ABT])
    else $error("abort flag on success");
  // A frozen edge leaves the scheduler idle, so the offer may wait
  a_retry_kept: assert property (ce && fail_ev
    && !abt_q[cur_q] && !ctrl_q[cur_q][cmx_pkg::B_SINGLE] && !reg_wr
    |=> ctrl_q[$past(cur_q)][cmx_pkg::B_TX_REQ]
    ##1 (st_q == cmx_pkg::TX_OFFER || !$past(ce)))
    else $error("normal box not retried");
  a_single_drop: assert property (ce && fail_ev
    && (ctrl_q[cur_q][cmx_pkg::B_SINGLE] || abt_q[cur_q]) |=>
    ctrl_q[$past(cur_q)][cmx_pkg::B_TX_ABT]
    && !ctrl_q[$past(cur_q)][cmx_pkg::B_TX_REQ])
    else $error("failed single attempt kept");
  a_fail_no_done: assert property (ce && fail_ev |=> !done_q)
    else $error("completion on failure");
  // Pulses freeze with ce low, so only a fresh pulse is traced back
  a_done_cause: assert property (done_q && $past(ce) |->
    $past(st_q) == cmx_pkg::TX_ACTIVE && $past(tx_ok))
    else $error("completion without win");
  a_abort_idle: assert property (ce && abt_q[0]
    && !(st_q != cmx_pkg::TX_IDLE && cur_q == '0) |=>
    ctrl_q[0][cmx_pkg::B_TX_ABT] && !abt_q[0])
    else $error("free abort not done");
  a_store_new: assert property (rx_store |->
    ctrl_q[rx_store_idx][cmx_pkg::B_RX_NEW])
    else $error("stored without new flag");
  a_overrun_lost: assert property (overrun_pulse && $past(ce) |->
    ctrl_q[$past(rx_pick[cmx_pkg::IDX_W-1:0])][cmx_pkg::B_RX_LOST]
    && !rx_store)
    else $error("overrun without lost");
  a_own_filtered: assert property (ce && rx_valid && rx_own
    && !cfg_q[cmx_pkg::C_SELF_TEST] |=> !rx_store && !overrun_pulse)
    else $error("own frame received");

endmodule

// File: core/cmx_pkg.sv
// Constants, register map and types for the mailbox transmit/receive control
package cmx_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int unsigned MBOX_NUM = 16; // Mailboxes per channel
  localparam int unsigned IDX_W = 4; // Mailbox index width
  localparam int unsigned ID_W = 29; // Identifier width
  localparam int unsigned ADDR_W = 6; // Register index width
  localparam int unsigned DATA_W = 32; // Register data width
  localparam int unsigned CTRL_W = 8; // Mailbox control width
  localparam int unsigned CFG_W = 3; // Configuration width

  // ************************************************************
  // Register map (word index on the register port)
  // ************************************************************
  localparam logic [1:0] SEL_CTRL = 2'h0; // 0x00..0x0f control
  localparam logic [1:0] SEL_ID = 2'h1; // 0x10..0x1f identifiers
  localparam logic [ADDR_W-1:0] MASK_ADDR = 6'h20; // Acceptance mask
  localparam logic [ADDR_W-1:0] CFG_ADDR = 6'h21; // Configuration
  localparam logic [ADDR_W-1:0] STAT_ADDR = 6'h22; // Scheduler state

  // ************************************************************
  // Mailbox control bit positions
  // ************************************************************
  localparam int unsigned B_RX_NEW = 0; // rx_new_flag
  localparam int unsigned B_TX_OK = 1; // tx_success_flag
  localparam int unsigned B_RX_LOST = 2; // rx_lost_flag
  localparam int unsigned B_TX_ABT = 3; // tx_abort_done_flag
  localparam int unsigned B_SINGLE = 4; // single_attempt_bit
  localparam int unsigned B_ABT_BUSY = 5; // Abort in progress, read only
  localparam int unsigned B_RX_REQ = 6; // rx_request_bit
  localparam int unsigned B_TX_REQ = 7; // tx_request_bit

  // ************************************************************
  // Configuration bit positions
  // ************************************************************
  localparam int unsigned C_LOST_MODE = 0; // lost_mode_select, 1 = overrun
  localparam int unsigned C_SELF_TEST = 1; // Receive own frames
  localparam int unsigned C_OVR_IE = 2; // Overrun event enable

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [ID_W-1:0] ID_RST = 29'h00000000;
  localparam logic [ID_W-1:0] MASK_RST = 29'h1fffffff;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;

  // Transmit scheduler states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_OFFER = 2'b01,
    TX_ACTIVE = 2'b10
  } cmx_tx_state_t;

endpackage

// File: verif/cmx_can_node_model.sv
// Far-side model: protocol engine and the other nodes on the bus
`timescale 1ns/1ps

module cmx_can_node_model #(
  parameter int FRAME_CYC = 6 // Start to outcome takes this many cycles plus one
) (
  input wire logic clk, // Peripheral clock
  input wire logic rst, // Synchronous reset
  input wire logic hold, // Bus busy, start is held back
  input wire logic [1:0] outcome, // 0 sent, 1 arbitration lost, 2 error
  input wire logic tx_valid, // Frame offered by the block
  output logic tx_start, // Frame begun
  output logic tx_ok, // Frame sent
  output logic tx_arb_lost, // Another node won
  output logic tx_bus_err // Bus error seen
);
  logic busy_q; // Frame on the bus
  logic [7:0] cnt_q; // Stand-in for the bit times of a frame

  // ************************************************************
  // Frame sequencing
  // ************************************************************
  // Pulses last one cycle and move right after the edge, like a real
  // engine; an offer withdrawn early leaves a stray outcome, ignored
  always_ff @(posedge clk) begin
    tx_start <= 1'b0;
    tx_ok <= 1'b0;
    tx_arb_lost <= 1'b0;
    tx_bus_err <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (!busy_q) begin
      // No start while hold is high
      if (tx_valid && !hold) begin
        tx_start <= 1'b1;
        busy_q <= 1'b1;
        cnt_q <= 8'h00;
      end
    end else if (cnt_q == 8'(FRAME_CYC)) begin
      busy_q <= 1'b0;
      tx_ok <= (outcome == 2'h0);
      tx_arb_lost <= (outcome == 2'h1);
      tx_bus_err <= (outcome == 2'h2);
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// File: verif/can_mailbox_tx_rx_control_test.sv
// Self-checking bench for the mailbox transmit and receive control
`timescale 1ns/1ps

module can_mailbox_tx_rx_control_test;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clk = 1'b0; // 40 MHz
  logic rst = 1'b1; // Held 12 cycles
  logic ce = 1'b1; // Low for one write in the reset test
  logic [cmx_pkg::ADDR_W-1:0] reg_addr = 6'h00;
  logic [cmx_pkg::DATA_W-1:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [cmx_pkg::DATA_W-1:0] reg_rdata;
  logic tx_valid, tx_start, tx_ok, tx_arb_lost, tx_bus_err;
  logic tx_done_pulse, rx_store, overrun_pulse, ack_own;
  logic [cmx_pkg::IDX_W-1:0] tx_index, rx_store_idx;
  logic rx_valid = 1'b0;
  logic rx_own = 1'b0;
  logic [cmx_pkg::ID_W-1:0] rx_id = 29'h00000000;
  logic hold = 1'b0; // Far side keeps the bus busy
  logic [1:0] outcome = 2'h0; // Far side verdict
  int miscompares = 0;
  int compares = 0;
  int done_cnt = 0; // Completion events
  int start_cnt = 0; // Frames begun
  int d0, s0; // Snapshots
  logic [31:0] v; // Last word read

  cmx_mailbox_ctrl u_cmx_mailbox_ctrl (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_index(tx_index), .tx_start(tx_start), .tx_ok(tx_ok),
    .tx_arb_lost(tx_arb_lost), .tx_bus_err(tx_bus_err),
    .tx_done_pulse(tx_done_pulse), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_own(rx_own), .rx_store(rx_store), .rx_store_idx(rx_store_idx),
    .overrun_pulse(overrun_pulse), .ack_own(ack_own));

  cmx_can_node_model u_cmx_can_node_model (.clk(clk), .rst(rst),
    .hold(hold), .outcome(outcome), .tx_valid(tx_valid),
    .tx_start(tx_start), .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost),
    .tx_bus_err(tx_bus_err));

  always #12.5 clk = ~clk;

  // Counted on the falling edge, clear of the rising-edge updates
  always @(negedge clk) begin
    if (tx_done_pulse === 1'b1) done_cnt++;
    if (tx_start === 1'b1) start_cnt++;
  end

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic cc(input logic [5:0] j, input logic [7:0] e);
    rd(j);
    chk(v, {24'h000000, e}, "mailbox control");
  endtask

  task automatic far(input logic h, input logic [1:0] o);
    @(posedge clk);
    hold <= h;
    outcome <= o;
  endtask

  // Software waits for request and abort-busy to clear, bounded
  task automatic poll(input logic [5:0] j);
    int n = 0;
    rd(j);
    while ((v[7] | v[5]) && n < 60) begin
      rd(j);
      n++;
    end
    if (n >= 60) chk(32'h1, 32'h0, "poll timeout");
  endtask

  task automatic wait_start();
    int n = 0;
    while (tx_start !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic rx(input logic [28:0] id, input logic own,
                    input logic st, input logic [3:0] ix, input logic ov);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_own <= own;
    @(posedge clk);
    rx_valid <= 1'b0;
    #1;
    chk({30'h0, rx_store, overrun_pulse}, {30'h0, st, ov}, "rx event");
    if (st) chk({28'h0, rx_store_idx}, {28'h0, ix}, "rx target");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run is a few hundred cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 16; j++) cc(6'(j), 8'h00);
    rd(6'h20);
    chk(v, 32'h1fffffff, "mask reset");
    wr(6'h3f, 32'hffffffff);
    rd(6'h3f);
    chk(v, 32'h0, "unmapped");
    // A write under a low clock enable must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    wr(6'h0d, 32'h80);
    @(posedge clk);
    ce <= 1'b1;
    cc(6'h0d, 8'h00);
    $display("test reset done");
    d0 = done_cnt;
    wr(6'h02, 32'h80);
    poll(6'h02);
    cc(6'h02, 8'h02);
    far(1'b0, 2'h1);
    s0 = start_cnt;
    wr(6'h03, 32'h80);
    repeat (40) @(posedge clk);
    cc(6'h03, 8'h80);
    chk(32'(start_cnt - s0 > 1), 32'h1, "retry");
    chk(32'(done_cnt - d0), 32'h1, "done count");
    far(1'b0, 2'h0);
    poll(6'h03);
    cc(6'h03, 8'h02);
    far(1'b0, 2'h2);
    s0 = start_cnt;
    wr(6'h04, 32'h90);
    poll(6'h04);
    cc(6'h04, 8'h18);
    chk(32'(start_cnt - s0), 32'h1, "one attempt");
    chk(32'(done_cnt - d0), 32'h2, "done count");
    far(1'b0, 2'h0);
    wr(6'h04, 32'h00);
    wr(6'h04, 32'h90);
    poll(6'h04);
    cc(6'h04, 8'h12);
    $display("test transmit done");
    far(1'b1, 2'h0);
    wr(6'h05, 32'h80);
    repeat (3) @(posedge clk);
    #1;
    chk({27'h0, tx_valid, tx_index}, 32'h15, "offer");
    // Box 0 is aborted while another box holds the offer
    wr(6'h00, 32'h80);
    wr(6'h00, 32'h00);
    cc(6'h00, 8'h08);
    wr(6'h05, 32'h00);
    poll(6'h05);
    cc(6'h05, 8'h08);
    far(1'b0, 2'h1);
    d0 = done_cnt;
    wr(6'h06, 32'h80);
    wait_start();
    wr(6'h06, 32'h00);
    poll(6'h06);
    cc(6'h06, 8'h08);
    far(1'b0, 2'h0);
    wr(6'h07, 32'h80);
    wait_start();
    wr(6'h07, 32'h00);
    poll(6'h07);
    cc(6'h07, 8'h02);
    chk(32'(done_cnt - d0), 32'h1, "done count");
    $display("test abort done");
    wr(6'h18, 32'h123);
    wr(6'h19, 32'h123);
    wr(6'h08, 32'h40);
    wr(6'h09, 32'h40);
    rx(29'h123, 1'b0, 1'b1, 4'h8, 1'b0);
    cc(6'h08, 8'h41);
    rx(29'h123, 1'b0, 1'b1, 4'h8, 1'b0);
    cc(6'h08, 8'h45);
    cc(6'h09, 8'h40);
    wr(6'h21, 32'h5);
    rx(29'h123, 1'b0, 1'b0, 4'h0, 1'b1);
    cc(6'h08, 8'h45);
    wr(6'h08, 32'h00);
    cc(6'h08, 8'h00);
    rx(29'h123, 1'b0, 1'b1, 4'h9, 1'b0);
    wr(6'h09, 32'h40);
    wr(6'h20, 32'h1ffffff0);
    rx(29'h12c, 1'b0, 1'b1, 4'h9, 1'b0);
    wr(6'h20, 32'h1fffffff);
    $display("test receive done");
    wr(6'h1a, 32'h55);
    wr(6'h1b, 32'h55);
    wr(6'h0a, 32'h50);
    wr(6'h0b, 32'h50);
    rx(29'h55, 1'b0, 1'b1, 4'ha, 1'b0);
    rx(29'h55, 1'b0, 1'b1, 4'hb, 1'b0);
    rx(29'h55, 1'b0, 1'b0, 4'h0, 1'b0);
    cc(6'h0a, 8'h51);
    $display("test single receive done");
    wr(6'h09, 32'h40);
    rx(29'h123, 1'b1, 1'b0, 4'h0, 1'b0);
    wr(6'h21, 32'h2);
    rd(6'h21);
    chk({31'h0, ack_own}, 32'h1, "own ack");
    rx(29'h123, 1'b1, 1'b1, 4'h9, 1'b0);
    wr(6'h1c, 32'h77);
    wr(6'h0c, 32'hc0);
    rx(29'h77, 1'b0, 1'b0, 4'h0, 1'b0);
    $display("test own and mode done");
    tally_and_finish();
  end
endmodule
